// ===== rtl/ddsc_pkg.sv
/*
 * Shared constants of the serial control front end: frame geometry,
 * control and status field positions, condition indices and timing.
 * Assumes a 100 MHz system clock; the serial clock is supplied by the master.
 */
`default_nettype none

package ddsc_pkg;
	// ****************************************************************
	// Frame geometry
	// ****************************************************************
	localparam int FRAME_BITS = 24;
	localparam int BITCNT_W = 5;
	localparam int TXIDX_W = 5;
	localparam logic [4:0] FRAME_LEN = 5'h18;
	localparam logic [4:0] BITCNT_FIRST = 5'h01;
	localparam logic [4:0] BITCNT_MAX = 5'h1F;
	localparam logic [4:0] TXIDX_LAST = 5'h17;
	localparam logic [23:0] WORD_RESET = 24'h000000;
	localparam int NUM_DRV = 6;
	localparam int NUM_COND = 16;

	// ****************************************************************
	// Control word fields
	// ****************************************************************
	localparam int C_SELECT = 0;
	localparam int C_DRV_LO = 1;
	localparam int C0_MON_LO = 18;
	localparam int C0_MON_HI = 19;
	localparam int C0_SUPPLY_LATCH = 20;
	localparam int C0_DUTY = 21;
	localparam int C0_CLEAR = 22;
	localparam int C0_ENABLE = 23;
	localparam int C1_RECOV_LO = 1;
	localparam int C1_PWM_LO = 7;
	localparam int PWM_B_DRV = 4;

	// ****************************************************************
	// Status word fields
	// ****************************************************************
	localparam int S_NO_ERROR = 0;
	localparam int S_FAULT_LO = 1;
	localparam int S_FAULT_HI = 22;
	localparam int S_ALWAYS_ONE = 23;
	localparam int S0_OV = 22;
	localparam int S0_UV = 21;
	localparam int S0_TSD = 20;
	localparam int S0_TW = 19;
	localparam int S1_OC_LO = 1;
	localparam int S1_OL_LO = 7;

	// ****************************************************************
	// Condition indices in the raw input vector
	// ****************************************************************
	localparam int COND_OC_LO = 0;
	localparam int COND_OL_LO = 6;
	localparam int COND_OV = 12;
	localparam int COND_UV = 13;
	localparam int COND_TSD = 14;
	localparam int COND_TW = 15;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int TB_W = 17;
	localparam int FILTER_TIME_NS = 32000;
	localparam int FILTER_CYC = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OPEN_LOAD_TIME_NS = 1000000;
	localparam int OPEN_LOAD_CYC = (OPEN_LOAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SLOW_PERIOD_NS = 666666;
	localparam int SLOW_PERIOD_CYC = SLOW_PERIOD_NS / CLK_PERIOD_NS;
	localparam int SLOW_ACTIVE_NS = 100000;
	localparam int SLOW_ACTIVE_CYC = SLOW_ACTIVE_NS / CLK_PERIOD_NS;
	localparam int FAST_PERIOD_NS = 333333;
	localparam int FAST_PERIOD_CYC = FAST_PERIOD_NS / CLK_PERIOD_NS;
	localparam int FAST_ACTIVE_NS = 83333;
	localparam int FAST_ACTIVE_CYC = FAST_ACTIVE_NS / CLK_PERIOD_NS;
endpackage

`default_nettype wire

// ===== rtl/ddsc_core.sv
/*
 * Serial control and diagnostic front end of a six-driver actuator chip:
 * 24-bit LSB-first frames, two control words, two status words, diagnostic
 * filters, standby, monitor select and over-current recovery pulsing.
 * Assumes a mode-0 master that clocks exactly 24 bits per frame, and
 * asynchronous raw diagnostic levels from the analog side.
 */
`default_nettype none

// How it works
// - Per-driver recovery bit restarts tripped driver
// - Recovery duty selectable, fifteen or twenty-five percent
// - Recovery pattern repeats at 1.5 or 3 kHz
// - Cleared recovery bit keeps tripped driver disabled
// - Sample input rising, change output falling
// - Frames travel least significant bit first
// - Deselected output floats; select frames the transfer
// - Selecting shows no-error bit before any clock
// - Bit zero is NOR of bits 1-22 of both status words
// - Shift in, commit at deselect edge
// - Only exactly 24 pulses commit a frame
// - First rise loads status, falls shift out
// - Bit zero picks word and returned status
// - Bits 1-12 hold driver controls
// - Enable bit zero means standby
// - Bits 18-19 pick monitored output
// - Clear bit wipes both status words
// - Over-current status disables its driver
// - Thermal shutdown status disables all drivers
// - Top status bit always reads one
// - Supply latch holds drivers off until cleared
// - Conditions filtered before status bit sets
// - Reset leaves standby with everything cleared
module ddsc_core #(
	parameter int P_OPEN_LOAD_CYC = ddsc_pkg::OPEN_LOAD_CYC,
	parameter int P_SLOW_PERIOD_CYC = ddsc_pkg::SLOW_PERIOD_CYC,
	parameter int P_SLOW_ACTIVE_CYC = ddsc_pkg::SLOW_ACTIVE_CYC,
	parameter int P_FAST_PERIOD_CYC = ddsc_pkg::FAST_PERIOD_CYC,
	parameter int P_FAST_ACTIVE_CYC = ddsc_pkg::FAST_ACTIVE_CYC
) (
	input wire logic i_clk,                      // System clock, 100 MHz
	input wire logic i_resetn,                   // Asynchronous reset, active low
	input wire logic i_serial_clk,               // Serial clock from the master
	input wire logic i_chip_select_low,          // Chip select, active low
	input wire logic i_serial_in,                // Serial data from the master
	output logic o_serial_out,                   // Serial data to the master
	output logic o_serial_out_en,                // Drive enable of serial data out
	input wire logic [5:0] i_overcurrent,        // Raw over-current per driver
	input wire logic [5:0] i_open_load,          // Raw open load per driver
	input wire logic i_overvoltage,              // Raw supply overvoltage
	input wire logic i_undervoltage,             // Raw supply undervoltage
	input wire logic i_thermal_shutdown_raw,     // Raw overtemperature
	input wire logic i_temperature_warning_raw,  // Raw temperature warning
	input wire logic i_ext_pwm_a,                // External PWM for drivers 0-3, 5
	input wire logic i_ext_pwm_b,                // External PWM for driver 4
	output logic [5:0] o_drive_en,               // Driver enables
	output logic [1:0] o_monitor_sel,            // Current monitor select
	output logic o_standby                       // Device in standby
);

	// ****************************************************************
	// Functions
	// ****************************************************************
	function automatic logic [4:0] sat_inc5(input logic [4:0] v, input logic [4:0] lim);
		sat_inc5 = (v == lim) ? v : v + 5'h01;
	endfunction

	function automatic logic [ddsc_pkg::TB_W-1:0] cond_limit(input int idx);
		if (idx >= ddsc_pkg::COND_OL_LO && idx < ddsc_pkg::COND_OV) begin
			cond_limit = ddsc_pkg::TB_W'(P_OPEN_LOAD_CYC);
		end else begin
			cond_limit = ddsc_pkg::TB_W'(ddsc_pkg::FILTER_CYC);
		end
	endfunction

	// ****************************************************************
	// Link domain: receive shifter and bit counter
	// ****************************************************************
	logic link_idle;
	logic link_arm_q;
	logic [23:0] rx_shift_q;
	logic [4:0] rx_cnt_q;
	logic frame_tgl_q;
	logic [23:0] tx_word_q;
	logic [4:0] tx_idx_q;
	logic [23:0] snap0_q;
	logic [23:0] snap1_q;
	logic no_error_q;

	assign link_idle = !i_resetn || i_chip_select_low;

	// Armed from deselect until the first rising serial clock
	always_ff @(posedge i_serial_clk or posedge link_idle) begin
		if (link_idle) begin
			link_arm_q <= 1'b1;
		end else begin
			link_arm_q <= 1'b0;
		end
	end

	always_ff @(posedge i_serial_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rx_shift_q <= ddsc_pkg::WORD_RESET;
			rx_cnt_q <= '0;
			frame_tgl_q <= 1'b0;
		end else begin
			rx_shift_q <= {i_serial_in, rx_shift_q[23:1]};
			if (link_arm_q) begin
				rx_cnt_q <= ddsc_pkg::BITCNT_FIRST;
				frame_tgl_q <= !frame_tgl_q;
			end else begin
				rx_cnt_q <= sat_inc5(rx_cnt_q, ddsc_pkg::BITCNT_MAX);
			end
		end
	end

	// ****************************************************************
	// Link domain: transmit
	// ****************************************************************
	always_ff @(posedge i_serial_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			tx_word_q <= ddsc_pkg::WORD_RESET;
		end else if (link_arm_q) begin
			tx_word_q <= i_serial_in ? snap1_q : snap0_q;
		end
	end

	// Bit index advances at falling edges, zero while armed
	always_ff @(negedge i_serial_clk or posedge link_arm_q) begin
		if (link_arm_q) begin
			tx_idx_q <= '0;
		end else begin
			tx_idx_q <= sat_inc5(tx_idx_q, ddsc_pkg::TXIDX_LAST);
		end
	end

	assign o_serial_out = link_arm_q ? no_error_q : tx_word_q[tx_idx_q];
	assign o_serial_out_en = !i_chip_select_low;

	// ****************************************************************
	// System domain: synchronisers
	// ****************************************************************
	logic csn_s1_q;
	logic csn_s2_q;
	logic csn_s3_q;
	logic tgl_s1_q;
	logic tgl_s2_q;
	logic tgl_seen_q;
	logic [ddsc_pkg::NUM_COND-1:0] raw;
	logic [ddsc_pkg::NUM_COND-1:0] raw_s1_q;
	logic [ddsc_pkg::NUM_COND-1:0] raw_s2_q;
	logic [1:0] pwm_s1_q;
	logic [1:0] pwm_s2_q;
	logic deselect_edge;
	logic commit;

	assign raw = {i_temperature_warning_raw, i_thermal_shutdown_raw, i_undervoltage,
		i_overvoltage, i_open_load, i_overcurrent};

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			csn_s1_q <= 1'b1;
			csn_s2_q <= 1'b1;
			csn_s3_q <= 1'b1;
			tgl_s1_q <= 1'b0;
			tgl_s2_q <= 1'b0;
			raw_s1_q <= '0;
			raw_s2_q <= '0;
			pwm_s1_q <= 2'h0;
			pwm_s2_q <= 2'h0;
		end else begin
			csn_s1_q <= i_chip_select_low;
			csn_s2_q <= csn_s1_q;
			csn_s3_q <= csn_s2_q;
			tgl_s1_q <= frame_tgl_q;
			tgl_s2_q <= tgl_s1_q;
			raw_s1_q <= raw;
			raw_s2_q <= raw_s1_q;
			pwm_s1_q <= {i_ext_pwm_b, i_ext_pwm_a};
			pwm_s2_q <= pwm_s1_q;
		end
	end

	assign deselect_edge = csn_s2_q && !csn_s3_q;

	// A frame with no clock leaves the toggle untouched and is dropped
	assign commit = deselect_edge && (tgl_s2_q != tgl_seen_q)
		&& (rx_cnt_q == ddsc_pkg::FRAME_LEN);

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			tgl_seen_q <= 1'b0;
		end else if (deselect_edge) begin
			tgl_seen_q <= tgl_s2_q;
		end
	end

	// ****************************************************************
	// Control words
	// ****************************************************************
	logic [23:0] ctrl0_q;
	logic [23:0] ctrl1_q;
	logic active;
	logic status_clear;

	assign active = ctrl0_q[ddsc_pkg::C0_ENABLE];

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ctrl0_q <= ddsc_pkg::WORD_RESET;
		end else if (commit && !rx_shift_q[ddsc_pkg::C_SELECT]) begin
			ctrl0_q <= rx_shift_q;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ctrl1_q <= ddsc_pkg::WORD_RESET;
		end else if (!active) begin
			ctrl1_q <= ddsc_pkg::WORD_RESET;
		end else if (commit && rx_shift_q[ddsc_pkg::C_SELECT]) begin
			ctrl1_q <= rx_shift_q;
		end
	end

	assign status_clear = !active
		|| (commit && !rx_shift_q[ddsc_pkg::C_SELECT] && rx_shift_q[ddsc_pkg::C0_CLEAR]);

	// ****************************************************************
	// Diagnostic filters
	// ****************************************************************
	logic [ddsc_pkg::TB_W-1:0] filt_cnt_q [ddsc_pkg::NUM_COND];
	logic [ddsc_pkg::NUM_COND-1:0] filt;

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			for (int i = 0; i < ddsc_pkg::NUM_COND; i++) begin
				filt_cnt_q[i] <= '0;
			end
		end else begin
			for (int i = 0; i < ddsc_pkg::NUM_COND; i++) begin
				if (!raw_s2_q[i]) begin
					filt_cnt_q[i] <= '0;
				end else if (filt_cnt_q[i] != cond_limit(i)) begin
					filt_cnt_q[i] <= filt_cnt_q[i] + 1'b1;
				end
			end
		end
	end

	always_comb begin
		for (int i = 0; i < ddsc_pkg::NUM_COND; i++) begin
			filt[i] = (filt_cnt_q[i] == cond_limit(i));
		end
	end

	// ****************************************************************
	// Status words
	// ****************************************************************
	logic [23:0] stat0_q;
	logic [23:0] stat1_q;
	logic [23:0] set0;
	logic [23:0] set1;

	always_comb begin
		set0 = ddsc_pkg::WORD_RESET;
		set1 = ddsc_pkg::WORD_RESET;
		if (active) begin
			set0[ddsc_pkg::S0_OV] = filt[ddsc_pkg::COND_OV];
			set0[ddsc_pkg::S0_UV] = filt[ddsc_pkg::COND_UV];
			set0[ddsc_pkg::S0_TSD] = filt[ddsc_pkg::COND_TSD];
			set0[ddsc_pkg::S0_TW] = filt[ddsc_pkg::COND_TW];
			for (int i = 0; i < ddsc_pkg::NUM_DRV; i++) begin
				set1[ddsc_pkg::S1_OC_LO + i] = filt[ddsc_pkg::COND_OC_LO + i];
				set1[ddsc_pkg::S1_OL_LO + i] = filt[ddsc_pkg::COND_OL_LO + i];
			end
		end
	end

	// A condition still present wins over a clear in the same cycle
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			stat0_q <= ddsc_pkg::WORD_RESET;
			stat1_q <= ddsc_pkg::WORD_RESET;
		end else begin
			stat0_q <= (status_clear ? ddsc_pkg::WORD_RESET : stat0_q) | set0;
			stat1_q <= (status_clear ? ddsc_pkg::WORD_RESET : stat1_q) | set1;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			no_error_q <= 1'b1;
		end else begin
			no_error_q <= !(|stat0_q[ddsc_pkg::S_FAULT_HI:ddsc_pkg::S_FAULT_LO]
				|| |stat1_q[ddsc_pkg::S_FAULT_HI:ddsc_pkg::S_FAULT_LO]);
		end
	end

	// Snapshots frozen while selected, so the link reads a stable word
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			snap0_q <= ddsc_pkg::WORD_RESET;
			snap1_q <= ddsc_pkg::WORD_RESET;
		end else if (csn_s2_q) begin
			snap0_q <= stat0_q;
			snap0_q[ddsc_pkg::S_NO_ERROR] <= no_error_q;
			snap0_q[ddsc_pkg::S_ALWAYS_ONE] <= 1'b1;
			snap1_q <= stat1_q;
			snap1_q[ddsc_pkg::S_NO_ERROR] <= no_error_q;
			snap1_q[ddsc_pkg::S_ALWAYS_ONE] <= 1'b1;
		end
	end

	// ****************************************************************
	// Recovery time base
	// ****************************************************************
	logic [ddsc_pkg::TB_W-1:0] tb_q;
	logic [ddsc_pkg::TB_W-1:0] tb_last;
	logic [ddsc_pkg::TB_W-1:0] tb_active;
	logic recov_window;

	assign tb_last = ctrl0_q[ddsc_pkg::C0_DUTY] ? ddsc_pkg::TB_W'(P_FAST_PERIOD_CYC - 1)
		: ddsc_pkg::TB_W'(P_SLOW_PERIOD_CYC - 1);
	assign tb_active = ctrl0_q[ddsc_pkg::C0_DUTY] ? ddsc_pkg::TB_W'(P_FAST_ACTIVE_CYC)
		: ddsc_pkg::TB_W'(P_SLOW_ACTIVE_CYC);

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			tb_q <= '0;
		end else if (tb_q >= tb_last) begin
			tb_q <= '0;
		end else begin
			tb_q <= tb_q + 1'b1;
		end
	end

	assign recov_window = (tb_q < tb_active);

	// ****************************************************************
	// Driver enables
	// ****************************************************************
	logic [5:0] drive_d;
	logic supply_block;
	logic thermal_block;

	assign supply_block = filt[ddsc_pkg::COND_OV] || filt[ddsc_pkg::COND_UV]
		|| (ctrl0_q[ddsc_pkg::C0_SUPPLY_LATCH]
		&& (stat0_q[ddsc_pkg::S0_OV] || stat0_q[ddsc_pkg::S0_UV]));
	assign thermal_block = stat0_q[ddsc_pkg::S0_TSD];

	always_comb begin
		logic req;
		logic pwm;
		logic oc_block;
		req = 1'b0;
		pwm = 1'b0;
		oc_block = 1'b0;
		drive_d = '0;
		for (int i = 0; i < ddsc_pkg::NUM_DRV; i++) begin
			pwm = (i == ddsc_pkg::PWM_B_DRV) ? pwm_s2_q[1] : pwm_s2_q[0];
			req = ctrl0_q[ddsc_pkg::C_DRV_LO + i]
				&& (!ctrl1_q[ddsc_pkg::C1_PWM_LO + i] || pwm);
			oc_block = stat1_q[ddsc_pkg::S1_OC_LO + i]
				&& !(ctrl1_q[ddsc_pkg::C1_RECOV_LO + i] && recov_window);
			drive_d[i] = active && req && !oc_block && !thermal_block && !supply_block;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_drive_en <= '0;
			o_monitor_sel <= '0;
			o_standby <= 1'b1;
		end else begin
			o_drive_en <= drive_d;
			o_monitor_sel <= ctrl0_q[ddsc_pkg::C0_MON_HI:ddsc_pkg::C0_MON_LO];
			o_standby <= !active;
		end
	end

endmodule

`default_nettype wire

// ===== tb/ddsc_core_checker.sv
/*
 * Concurrent checks on the ports of ddsc_core, bound to every instance.
 * Assumes a 100 MHz system clock and a serial clock idle low between frames.
 */
`default_nettype none

module ddsc_core_checker (
	input wire logic i_clk,                  // System clock
	input wire logic i_resetn,               // Reset, active low
	input wire logic i_serial_clk,           // Serial clock
	input wire logic i_chip_select_low,      // Chip select, active low
	input wire logic [5:0] i_overcurrent,    // Raw over-current
	input wire logic i_thermal_shutdown_raw, // Raw overtemperature
	input wire logic o_serial_out,           // Serial data out
	input wire logic o_serial_out_en,        // Serial out enable
	input wire logic [5:0] o_drive_en,       // Driver enables
	input wire logic [1:0] o_monitor_sel,    // Monitor select
	input wire logic o_standby               // Standby flag
);
	// ****************************************************************
	// Helper state
	// ****************************************************************
	logic seen_q;
	logic [3:0] since_q;
	logic [12:0] th_q;
	logic [12:0] flt_q;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			seen_q <= 1'b0;
			since_q <= 4'h0;
			th_q <= 13'h0000;
			flt_q <= 13'h0000;
		end else begin
			seen_q <= !i_chip_select_low && (seen_q || i_serial_clk);
			since_q <= !i_chip_select_low ? 4'h0 : since_q + {3'h0, ~&since_q};
			th_q <= i_thermal_shutdown_raw ? th_q + {12'h000, ~&th_q} : 13'h0000;
			flt_q <= (i_thermal_shutdown_raw || |i_overcurrent) ?
				flt_q + {12'h000, ~&flt_q} : 13'h0000;
		end
	end

	// ****************************************************************
	// Properties
	// ****************************************************************
	sequence s_in_frame;
		!i_chip_select_low [*6];
	endsequence
	sequence s_fault_poll;
		!i_chip_select_low && !seen_q && !i_serial_clk && th_q >= 13'hD48;
	endsequence

	chk_out_enable: assert property (o_serial_out_en == !i_chip_select_low)
		else $error("serial out enable does not follow chip select");
	chk_poll_fault: assert property (s_fault_poll |-> !o_serial_out)
		else $error("fault poll shows no error during thermal shutdown");
	chk_standby_off: assert property (o_standby [*2] |-> o_drive_en == 6'h00)
		else $error("driver enabled in standby");
	chk_standby_hold: assert property (s_in_frame |-> $stable(o_standby))
		else $error("standby changed inside a frame");
	chk_monitor_commit: assert property ($changed(o_monitor_sel) |-> $past(i_chip_select_low, 2))
		else $error("monitor select changed while selected");
	chk_thermal_off: assert property (th_q >= 13'hCE4 |-> o_drive_en == 6'h00)
		else $error("driver on during thermal shutdown");
	chk_fall_cause: assert property (|($past(o_drive_en) & ~o_drive_en) |->
		since_q < 4'h8 || flt_q >= 13'hC80)
		else $error("driver switched off without frame or filtered fault");
	chk_rise_cause: assert property (|(~$past(o_drive_en) & o_drive_en) |->
		since_q < 4'h8 || flt_q >= 13'hC80)
		else $error("driver switched on without frame or recovery");
endmodule

bind ddsc_core ddsc_core_checker chk_u (
	.i_clk(i_clk), .i_resetn(i_resetn), .i_serial_clk(i_serial_clk),
	.i_chip_select_low(i_chip_select_low), .i_overcurrent(i_overcurrent),
	.i_thermal_shutdown_raw(i_thermal_shutdown_raw), .o_serial_out(o_serial_out),
	.o_serial_out_en(o_serial_out_en), .o_drive_en(o_drive_en),
	.o_monitor_sel(o_monitor_sel), .o_standby(o_standby)
);

`default_nettype wire

// ===== tb/ddsc_spi_master.sv
/*
 * Behavioural mode-0 serial master standing in for the microcontroller.
 * Assumes the bench floats the device's data-out line when not driven.
 */
`default_nettype none

module ddsc_spi_master (
	output logic o_sclk,    // Serial clock, idle low
	output logic o_csn,     // Chip select, active low
	output logic o_mosi,    // Data to the device
	input wire logic i_miso // Data from the device
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [23:0] rx;
	event done;

	initial begin
		o_sclk = 1'b0;
		o_csn = 1'b1;
		o_mosi = 1'b0;
	end

	// ****************************************************************
	// Frame of n pulses; n of 0 is a fault poll
	// ****************************************************************
	task automatic frame(input logic [23:0] tx, input int n);
		logic [23:0] r;
		r = 24'h000000;
		#3 o_csn = 1'b0;
		#16;
		if (n == 0) r[0] = i_miso;
		for (int i = 0; i < n; i++) begin
			o_mosi = tx[i % 24];
			#16;
			if (i < 24) r[i] = i_miso;
			o_sclk = 1'b1;
			#16 o_sclk = 1'b0;
		end
		#16 o_csn = 1'b1;
		o_mosi = ~o_mosi;
		rx = r;
		-> done;
		#200;
	endtask
endmodule

`default_nettype wire

// ===== tb/testbench.sv
/*
 * Self-checking bench of ddsc_core driven by a behavioural serial master.
 * Assumes shortened recovery periods of 200/30 and 100/25 system cycles.
 */
`default_nettype none

`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; $display("BAD %s exp=%0h got=%0h", nm, e, g); end end

module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, resetn, flt_q, th, tw, stby, so, so_en, pwm_a, pwm_b, pw, ov, uv;
	logic [5:0] oc, dv, drv, ol;
	logic [1:0] mon, msel;
	logic [23:0] e_v, m_v;
	logic [23:0] exp_q[$];
	logic [23:0] msk_q[$];
	int fail_count, samples_checked, k, hi, rises;
	wire sclk, chip_select_low, mosi, miso;

	assign miso = so_en ? so : flt_q;

	ddsc_spi_master mst_u (.o_sclk(sclk), .o_csn(chip_select_low), .o_mosi(mosi), .i_miso(miso));

	ddsc_core #(.P_OPEN_LOAD_CYC(50), .P_SLOW_PERIOD_CYC(200), .P_SLOW_ACTIVE_CYC(30),
		.P_FAST_PERIOD_CYC(100), .P_FAST_ACTIVE_CYC(25)) dut_u (
		.i_clk(clk), .i_resetn(resetn), .i_serial_clk(sclk), .i_chip_select_low(chip_select_low),
		.i_serial_in(mosi), .o_serial_out(so), .o_serial_out_en(so_en),
		.i_overcurrent(oc), .i_open_load(ol), .i_overvoltage(ov), .i_undervoltage(uv),
		.i_thermal_shutdown_raw(th), .i_temperature_warning_raw(tw), .i_ext_pwm_a(pwm_a),
		.i_ext_pwm_b(pwm_b), .o_drive_en(drv), .o_monitor_sel(msel), .o_standby(stby));

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [23:0] w0(logic [5:0] d, logic [1:0] m, logic dy, logic clr,
		logic en);
		return {en, clr, dy, 1'b0, m, 11'h000, d, 1'b0};
	endfunction
	function automatic logic [23:0] st1(int j);
		return 24'h800000 | (24'h000002 << j);
	endfunction
	task automatic wclk(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic xfer(input logic [23:0] tx, input int n, input logic [23:0] e,
		input logic [23:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		mst_u.frame(tx, n);
		wclk(10);
	endtask
	task automatic measure();
		logic p;
		hi = 0;
		rises = 0;
		p = drv[k];
		repeat (1000) begin
			@(posedge clk);
			#1;
			if (drv[k]) hi++;
			if (drv[k] && !p) rises++;
			p = drv[k];
		end
		wclk(1);
	endtask
	task automatic finish_test();
		if (fail_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	always @(mst_u.done) begin
		e_v = exp_q.pop_front();
		m_v = msk_q.pop_front();
		`CHK("rx_word", e_v, mst_u.rx & m_v)
	end

	always @(posedge clk) flt_q <= ~flt_q;

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		wclk(80000);
		fail_count++;
		finish_test();
	end

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	initial begin
		resetn = 1'b0;
		oc = 6'h00;
		th = 1'b0;
		tw = 1'b0;
		ol = 6'h00;
		ov = 1'b0;
		uv = 1'b0;
		flt_q = 1'b0;
		fail_count = 0;
		samples_checked = 0;
		void'($urandom(32'h5D97));
		k = $urandom_range(5, 0);
		dv = 6'($urandom) | (6'h01 << k);
		mon = 2'($urandom);
		pwm_a = 1'($urandom);
		pwm_b = 1'($urandom);
		pw = (k == ddsc_pkg::PWM_B_DRV) ? pwm_b : pwm_a;
		wclk(2);
		resetn <= 1'b1;
		wclk(3);
		`CHK("standby", 1'b1, stby)
		`CHK("drive_en", 6'h00, drv)
		xfer(24'h000000, 0, 24'h000001, 24'h000001);
		xfer(w0(dv, mon, 1'b0, 1'b0, 1'b1), 24, 24'h800001, 24'hFFFFFF);
		`CHK("drive_en", dv, drv)
		`CHK("monitor", mon, msel)
		`CHK("standby", 1'b0, stby)
		for (int n = 23; n <= 25; n += 2) begin
			xfer(w0(~dv, ~mon, 1'b0, 1'b0, 1'b0), n, 24'h000001, 24'h7FFFFF);
			`CHK("drive_en", dv, drv)
			`CHK("monitor", mon, msel)
		end
		xfer({17'h00000, 6'h00, 1'b1}, 24, 24'h800001, 24'hFFFFFF);
		oc <= 6'h01 << k;
		wclk(3000);
		`CHK("drive_en", dv, drv)
		wclk(400);
		`CHK("drive_en", dv & ~(6'h01 << k), drv)
		xfer(24'h000000, 0, 24'h000000, 24'h000001);
		xfer({17'h00000, 6'h00, 1'b1}, 24, st1(k), 24'hFFFFFF);
		oc <= 6'h00;
		wclk(3400);
		`CHK("drive_en", dv & ~(6'h01 << k), drv)
		xfer(w0(dv, mon, 1'b0, 1'b1, 1'b1), 24, 24'h800000, 24'hFFFFFF);
		`CHK("drive_en", dv, drv)
		xfer({17'h00000, 6'h01 << k, 1'b1}, 24, 24'h800001, 24'hFFFFFF);
		oc <= 6'h01 << k;
		wclk(3600);
		for (int dy = 0; dy < 2; dy++) begin
			xfer(w0(dv, mon, dy[0], 1'b1, 1'b1), 24, 24'h800000, 24'hFFFFFE);
			wclk(300);
			measure();
			`CHK("on_cycles", dy ? 250 : 150, hi)
			`CHK("pulses", dy ? 10 : 5, rises)
		end
		xfer({17'h00000, 6'h00, 1'b1}, 24, st1(k), 24'hFFFFFF);
		measure();
		`CHK("on_cycles", 0, hi)
		oc <= 6'h00;
		xfer(w0(dv, mon, 1'b0, 1'b1, 1'b1), 24, 24'h800000, 24'hFFFFFF);
		`CHK("drive_en", dv, drv)
		xfer(24'h000001 | (24'h000080 << k), 24, 24'h800001, 24'hFFFFFF);
		`CHK("drive_en", (dv & ~(6'h01 << k)) | ({5'h00, pw} << k), drv)
		xfer(24'h000001, 24, 24'h800001, 24'hFFFFFF);
		`CHK("drive_en", dv, drv)
		th <= 1'b1;
		tw <= 1'b1;
		wclk(3400);
		`CHK("drive_en", 6'h00, drv)
		xfer(w0(dv, mon, 1'b0, 1'b0, 1'b1), 24, 24'h980000, 24'hFFFFFF);
		th <= 1'b0;
		tw <= 1'b0;
		wclk(3400);
		`CHK("drive_en", 6'h00, drv)
		xfer(w0(dv, mon, 1'b0, 1'b1, 1'b1), 24, 24'h980000, 24'hFFFFFF);
		`CHK("drive_en", dv, drv)
		xfer(w0(dv, mon, 1'b0, 1'b0, 1'b0), 24, 24'h800001, 24'hFFFFFF);
		`CHK("standby", 1'b1, stby)
		`CHK("drive_en", 6'h00, drv)
		finish_test();
	end
endmodule

`default_nettype wire
